// ==== logic/pibw_top.v ====
// pin muxing, isolation strap and external bus read/wait control
`timescale 1ns/1ps
`include "pibw_regs.vh"
module pibw_top #(
  parameter PWM_W = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // isolation strap
  input wire i_emul_isolate_pin,
  output wire o_isolated,
  // port one pins
  input wire [7:0] i_p1_pin,
  output wire [7:0] o_p1_out,
  output wire [7:0] o_p1_oe,
  // port one core side
  input wire [7:0] i_p1_gp_out,
  input wire [7:0] i_p1_gp_oe,
  input wire [7:0] i_p1_sel,
  input wire [7:0] i_p1_sf_out,
  input wire [7:0] i_p1_sf_oe,
  output wire [7:0] o_p1_in,
  output wire [3:0] o_capture_channel_pins,
  output wire o_timer_one_clock_in,
  output wire o_timer_one_dir_in,
  // port two pins
  input wire [7:0] i_p2_pin,
  output wire [7:0] o_p2_out,
  output wire [7:0] o_p2_oe,
  // port two core side
  input wire [7:0] i_p2_gp_out,
  input wire [7:0] i_p2_gp_oe,
  input wire [7:0] i_p2_sel,
  input wire [7:0] i_p2_sf_out,
  input wire [7:0] i_p2_sf_oe,
  input wire i_bus_hold_ack_n,
  output wire [7:0] o_p2_in,
  // port three pins
  input wire [7:0] i_p3_pin,
  output wire [7:0] o_p3_out,
  output wire [7:0] o_p3_oe,
  // port three core side
  input wire [7:0] i_p3_gp_out,
  input wire [7:0] i_p3_gp_oe,
  input wire [7:0] i_p3_sel,
  input wire [5:0] i_chip_select_outputs,
  output wire [7:0] o_p3_in,
  output wire o_ext_irq_two,
  output wire o_ext_irq_three,
  // port four pins
  input wire [3:0] i_p4_pin,
  output wire [3:0] o_p4_out,
  output wire [3:0] o_p4_oe,
  // port four core side
  input wire [3:0] i_p4_gp_out,
  input wire [3:0] i_p4_gp_oe,
  input wire [3:0] i_p4_sel,
  output wire [3:0] o_p4_in,
  // duty wave settings
  input wire [2:0] i_pwm_enable,
  input wire [3*PWM_W-1:0] i_pwm_period,
  input wire [3*PWM_W-1:0] i_pwm_duty,
  // bus cycle request from core
  input wire i_bus_req,
  input wire i_bus_ext,
  input wire i_bus_read,
  input wire [1:0] i_bus_wait,
  // bus pins
  input wire i_ready_pin,
  output wire o_rd_n,
  output wire o_rd_n_oe,
  // bus status to core
  output wire o_bus_busy,
  output wire o_bus_done
);

  function [7:0] pibw_pick;
    input [7:0] sel;
    input [7:0] sf;
    input [7:0] gp;
    begin
      pibw_pick = (sel & sf) | (~sel & gp);
    end
  endfunction

  // synchronised pins
  wire [29:0] pins_s;
  wire [2:0] duty_wave_outputs;
  wire iso_s;
  wire ready_s;

  pibw_sync #(
    .W(30)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_pin({i_ready_pin, i_emul_isolate_pin, i_p4_pin, i_p3_pin,
            i_p2_pin, i_p1_pin}),
    .o_level(pins_s)
  );

  assign ready_s = pins_s[29];
  assign iso_s = pins_s[28];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pwm
      pibw_pwm #(
        .W(PWM_W)
      ) u_pwm (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_enable(i_pwm_enable[g]),
        .i_period(i_pwm_period[g*PWM_W +: PWM_W]),
        .i_duty(i_pwm_duty[g*PWM_W +: PWM_W]),
        .o_wave(duty_wave_outputs[g])
      );
    end
  endgenerate

  // isolation strap capture
  reg rst_seen_q;
  reg isolated_q;

  always @(posedge i_ref_clk) begin
    rst_seen_q <= i_reset;
    if (i_reset) begin
      isolated_q <= 1'b0;
    end else if (rst_seen_q) begin
      // first edge after release only; later changes never reach here
      isolated_q <= iso_s;
    end
  end

  // pin output selection
  wire [7:0] p2_sf_out;
  wire [7:0] p2_sf_oe;
  wire [7:0] p3_sf_out;
  wire [7:0] p3_sf_oe;
  wire [7:0] p4_sf_out;
  wire [7:0] p4_sf_oe;
  wire [7:0] p4_pick_out;
  wire [7:0] p4_pick_oe;
  wire float_pins;

  assign p2_sf_out = {i_p2_sf_out[7], i_bus_hold_ack_n, i_p2_sf_out[5:0]};
  assign p2_sf_oe = {i_p2_sf_oe[7], 1'b1, i_p2_sf_oe[5:0]};
  // chip selects drive low bits, irq bits are inputs only
  assign p3_sf_out = {2'b11, i_chip_select_outputs};
  assign p3_sf_oe = 8'h3F;
  assign p4_sf_out = {5'h00, duty_wave_outputs};
  assign p4_sf_oe = 8'h07;
  assign p4_pick_out = pibw_pick({4'h0, i_p4_sel}, p4_sf_out,
                                 {4'h0, i_p4_gp_out});
  assign p4_pick_oe = pibw_pick({4'h0, i_p4_sel}, p4_sf_oe,
                                {4'h0, i_p4_gp_oe});
  // release edge still floats: the strap is only caught on that edge
  assign float_pins = i_reset | rst_seen_q | isolated_q;

  reg [7:0] p1_out_q;
  reg [7:0] p1_oe_q;
  reg [7:0] p2_out_q;
  reg [7:0] p2_oe_q;
  reg [7:0] p3_out_q;
  reg [7:0] p3_oe_q;
  reg [3:0] p4_out_q;
  reg [3:0] p4_oe_q;

  always @(posedge i_ref_clk) begin
    if (float_pins) begin
      p1_out_q <= `PIBW_OUT8_RST;
      p2_out_q <= `PIBW_OUT8_RST;
      p3_out_q <= `PIBW_OUT8_RST;
      p4_out_q <= `PIBW_OUT4_RST;
      p1_oe_q <= `PIBW_OE8_RST;
      p2_oe_q <= `PIBW_OE8_RST;
      p3_oe_q <= `PIBW_OE8_RST;
      p4_oe_q <= `PIBW_OE4_RST;
    end else begin
      p1_out_q <= pibw_pick(i_p1_sel, i_p1_sf_out, i_p1_gp_out);
      p1_oe_q <= pibw_pick(i_p1_sel, i_p1_sf_oe, i_p1_gp_oe);
      p2_out_q <= pibw_pick(i_p2_sel, p2_sf_out, i_p2_gp_out);
      p2_oe_q <= pibw_pick(i_p2_sel, p2_sf_oe, i_p2_gp_oe);
      p3_out_q <= pibw_pick(i_p3_sel, p3_sf_out, i_p3_gp_out);
      p3_oe_q <= pibw_pick(i_p3_sel, p3_sf_oe, i_p3_gp_oe);
      p4_out_q <= p4_pick_out[3:0];
      p4_oe_q <= p4_pick_oe[3:0];
    end
  end

  // external bus cycle sequencer
  reg [4:0] state_q;
  reg [4:0] state_d;
  reg [1:0] wcnt_q;
  reg [1:0] wcnt_d;
  reg ext_q;
  reg ext_d;
  reg rdcyc_q;
  reg rdcyc_d;
  reg rd_n_q;
  reg rd_n_d;
  reg busy_q;
  reg busy_d;
  reg done_q;
  reg done_d;
  reg rd_oe_q;

  always @* begin
    state_d = state_q;
    wcnt_d = wcnt_q;
    ext_d = ext_q;
    rdcyc_d = rdcyc_q;
    rd_n_d = rd_n_q;
    busy_d = busy_q;
    done_d = 1'b0;
    case (state_q)
      `PIBW_ST_IDLE: begin
        if (i_bus_req) begin
          state_d = `PIBW_ST_ADDR;
          ext_d = i_bus_ext;
          rdcyc_d = i_bus_ext & i_bus_read;
          wcnt_d = i_bus_wait;
          busy_d = 1'b1;
          // strobe only for external reads
          rd_n_d = ~(i_bus_ext & i_bus_read);
        end
      end
      `PIBW_ST_ADDR: begin
        if (!ext_q) begin
          // internal: no waits, ready not looked at
          state_d = `PIBW_ST_DONE;
          busy_d = 1'b0;
          done_d = 1'b1;
        end else if (wcnt_q == 2'h0) begin
          state_d = `PIBW_ST_RDY;
        end else begin
          state_d = `PIBW_ST_WAIT;
          wcnt_d = wcnt_q - 2'h1;
        end
      end
      `PIBW_ST_WAIT: begin
        if (wcnt_q == 2'h0) begin
          state_d = `PIBW_ST_RDY;
        end else begin
          wcnt_d = wcnt_q - 2'h1;
        end
      end
      `PIBW_ST_RDY: begin
        // one sample per state; low adds a state, high ends the cycle
        if (ready_s) begin
          state_d = `PIBW_ST_DONE;
          rd_n_d = 1'b1;
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          state_d = `PIBW_ST_RDY;
        end
      end
      `PIBW_ST_DONE: begin
        state_d = `PIBW_ST_IDLE;
        rdcyc_d = 1'b0;
      end
      default: begin
        state_d = `PIBW_ST_IDLE;
        rd_n_d = 1'b1;
        busy_d = 1'b0;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= `PIBW_ST_IDLE;
      wcnt_q <= `PIBW_WCNT_RST;
      ext_q <= 1'b0;
      rdcyc_q <= 1'b0;
      rd_n_q <= `PIBW_RD_N_RST;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rd_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wcnt_q <= wcnt_d;
      ext_q <= ext_d;
      rdcyc_q <= rdcyc_d;
      rd_n_q <= rd_n_d;
      busy_q <= busy_d;
      done_q <= done_d;
      // strobe pin floats too while isolated
      rd_oe_q <= ~(rst_seen_q | isolated_q);
    end
  end

  // outputs
  assign o_isolated = isolated_q;
  assign o_p1_out = p1_out_q;
  assign o_p1_oe = p1_oe_q;
  assign o_p2_out = p2_out_q;
  assign o_p2_oe = p2_oe_q;
  assign o_p3_out = p3_out_q;
  assign o_p3_oe = p3_oe_q;
  assign o_p4_out = p4_out_q;
  assign o_p4_oe = p4_oe_q;
  assign o_p1_in = pins_s[7:0];
  assign o_p2_in = pins_s[15:8];
  assign o_p3_in = pins_s[23:16];
  assign o_p4_in = pins_s[27:24];
  assign o_capture_channel_pins = pins_s[3:0];
  assign o_timer_one_clock_in = pins_s[`PIBW_P1_TCLK_BIT];
  assign o_timer_one_dir_in = pins_s[`PIBW_P1_TDIR_BIT];
  assign o_ext_irq_two = pins_s[16 + `PIBW_P3_IRQ2_BIT];
  assign o_ext_irq_three = pins_s[16 + `PIBW_P3_IRQ3_BIT];
  assign o_rd_n = rd_n_q;
  assign o_rd_n_oe = rd_oe_q;
  assign o_bus_busy = busy_q;
  assign o_bus_done = done_q;
endmodule // pibw_top

// ==== logic/pibw_regs.vh ====
// constants for the pin isolation and bus wait block
// What this block does
// - isolation mode is entered when the isolate pin is high as reset releases.
// - in isolation mode every pin output enable is held off so pins float.
// - the isolate pin is caught emul_isolate_pin at reset release and ignored after.
// - isolation mode is left only through another reset.
// - each bit of ports one and two picks general I/O or its special signal.
// - port three has eight bits, low six shared with chip selects, top two irqs.
// - port four has four bits, low three shared with the duty wave outputs.
// - each of the three duty wave outputs has programmable duty and period.
// - the active-low read strobe goes low only for external read cycles.
// - a low ready input adds wait states beyond the programmed ones.
// - with ready high an external cycle uses only the programmed waits.
// - ready is ignored for internal accesses, which are never stretched.
`ifndef PIBW_REGS_VH
`define PIBW_REGS_VH

// bus cycle states, one-hot
`define PIBW_ST_IDLE 5'h01
`define PIBW_ST_ADDR 5'h02
`define PIBW_ST_WAIT 5'h04
`define PIBW_ST_RDY 5'h08
`define PIBW_ST_DONE 5'h10

// special-function bit positions
`define PIBW_P1_TCLK_BIT 4
`define PIBW_P1_TDIR_BIT 5
`define PIBW_P2_BUS_HOLD_ACK_N_BIT 6
`define PIBW_P3_IRQ2_BIT 6
`define PIBW_P3_IRQ3_BIT 7

// reset values
`define PIBW_OE8_RST 8'h00
`define PIBW_OE4_RST 4'h0
`define PIBW_OUT8_RST 8'hFF
`define PIBW_OUT4_RST 4'hF
`define PIBW_RD_N_RST 1'b1
`define PIBW_WCNT_RST 2'h0

`endif

// ==== logic/pibw_sync.v ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pibw_sync #(
  parameter W = 1
) (
  // clock
  input wire i_ref_clk,
  // raw pins and filtered levels
  input wire [W-1:0] i_pin,
  output wire [W-1:0] o_level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] level_q;

  // no reset: the strap must be seen while reset is still held
  always @(posedge i_ref_clk) begin
    s1_q <= i_pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
    // take the new value only where stages two and three agree
    level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
  end

  assign o_level = level_q;
endmodule // pibw_sync

// ==== logic/pibw_pwm.v ====
// one duty wave channel with programmable period and duty
`timescale 1ns/1ps
module pibw_pwm #(
  parameter W = 8
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // settings
  input wire i_enable,
  input wire [W-1:0] i_period,
  input wire [W-1:0] i_duty,
  // wave
  output wire o_wave
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  reg wave_q;

  always @* begin
    if (!i_enable || cnt_q >= i_period) begin
      cnt_d = {W{1'b0}};
    end else begin
      cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_q <= {W{1'b0}};
      wave_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      // period is period+1 counts, high while count below duty
      wave_q <= i_enable && (cnt_q < i_duty);
    end
  end

  assign o_wave = wave_q;
endmodule // pibw_pwm

// ==== testbench/pibw_properties.sv ====
// concurrent checks on the pin isolation and bus wait top
`timescale 1ns/1ps
module pibw_props (
  // clock and reset
  input wire i_ref_clk,
  input wire i_reset,
  // bus request
  input wire i_bus_req,
  input wire i_bus_ext,
  input wire i_bus_read,
  input wire [1:0] i_bus_wait,
  // watched outputs
  input wire o_isolated,
  input wire [7:0] o_p1_oe,
  input wire [7:0] o_p2_oe,
  input wire [7:0] o_p3_oe,
  input wire [3:0] o_p4_oe,
  input wire o_rd_n,
  input wire o_rd_n_oe,
  input wire o_bus_busy,
  input wire o_bus_done
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // busy and done both low only in the idle state
  wire take = i_bus_req && !o_bus_busy && !o_bus_done;
  wire oe_any = |{o_p1_oe, o_p2_oe, o_p3_oe, o_p4_oe};
  iso_float_a: assert property (o_isolated |=>
    !oe_any && !o_rd_n_oe)
    else $error("pin driven while isolated");
  float_release_a: assert property ($past(i_reset, 2) &&
    !$past(i_reset) |-> !oe_any && !o_rd_n_oe)
    else $error("pin driven at reset release");
  // the capture edge itself changes the flag, so skip two edges
  iso_keep_a: assert property (!$past(i_reset) &&
    !$past(i_reset, 2) |-> $stable(o_isolated))
    else $error("isolation changed without reset");
  int_cycle_a: assert property (take && !i_bus_ext |=>
    o_rd_n && o_bus_busy ##1 o_bus_done)
    else $error("internal cycle wrong");
  ext_read_a: assert property (take && i_bus_ext && i_bus_read |=>
    !o_rd_n && o_bus_busy)
    else $error("external read strobe missing");
  write_strobe_a: assert property (take && !i_bus_read |=>
    o_rd_n [*2])
    else $error("strobe on write");
  wait_three_a: assert property (take && i_bus_ext &&
    i_bus_wait == 2'h3 |=> !o_bus_done [*4])
    else $error("programmed waits cut short");
  done_pulse_a: assert property (o_bus_done |=>
    !o_bus_done && !o_bus_busy)
    else $error("done longer than one cycle");
  busy_end_a: assert property ($fell(o_bus_busy) |->
    o_bus_done && o_rd_n)
    else $error("cycle ended without done");
  strobe_span_a: assert property (!o_rd_n |-> o_bus_busy)
    else $error("strobe outside a cycle");
endmodule // pibw_props

bind pibw_top pibw_props u_props (.*);

// ==== testbench/pibw_mem_model.sv ====
// external memory model that stalls reads through the ready pin
`timescale 1ns/1ps
module pibw_mem_model (
  // clock
  input wire i_ref_clk,
  // strobe from the device, stall length from the bench
  input wire i_rd_n,
  input wire [3:0] i_slow,
  // ready pin to the device
  output reg o_ready
);
  reg [3:0] cnt_q;
  initial begin
    cnt_q = 4'h0;
    o_ready = 1'b1;
  end
  // a slow part holds ready low even between strobes
  always @(posedge i_ref_clk) begin
    if (i_rd_n) begin
      cnt_q <= 4'h0;
      o_ready <= (i_slow == 4'h0);
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q + 4'h1 >= i_slow) o_ready <= 1'b1;
    end
  end
endmodule // pibw_mem_model

// ==== testbench/tb.sv ====
// self-checking bench for the pin isolation and bus wait top
`timescale 1ns/1ps
module tb;
  reg i_ref_clk, i_reset, i_emul_isolate_pin, i_bus_hold_ack_n;
  reg i_bus_req, i_bus_ext, i_bus_read;
  reg [7:0] i_p1_pin, i_p1_gp_out, i_p1_gp_oe, i_p1_sel, i_p1_sf_out;
  reg [7:0] i_p1_sf_oe, i_p2_pin, i_p2_gp_out, i_p2_gp_oe, i_p2_sel;
  reg [7:0] i_p2_sf_out, i_p2_sf_oe, i_p3_pin, i_p3_gp_out, i_p3_gp_oe;
  reg [7:0] i_p3_sel;
  reg [5:0] i_chip_select_outputs;
  reg [3:0] i_p4_pin, i_p4_gp_out, i_p4_gp_oe, i_p4_sel, slow;
  reg [2:0] i_pwm_enable;
  reg [23:0] i_pwm_period, i_pwm_duty;
  reg [1:0] i_bus_wait;
  reg [31:0] r;
  wire i_ready_pin;
  wire [7:0] o_p1_out, o_p1_oe, o_p1_in, o_p2_out, o_p2_oe, o_p2_in;
  wire [7:0] o_p3_out, o_p3_oe, o_p3_in;
  wire [3:0] o_p4_out, o_p4_oe, o_p4_in, o_capture_channel_pins;
  wire o_isolated, o_timer_one_clock_in, o_timer_one_dir_in;
  wire o_ext_irq_two, o_ext_irq_three, o_rd_n, o_rd_n_oe;
  wire o_bus_busy, o_bus_done;
  integer seed = 77;
  integer miscompares = 0;
  integer checks_done = 0;
  integer i, g, k, ones, bad;
  integer smp [0:59];

  pibw_top dut (.*);
  pibw_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_rd_n(o_rd_n),
    .i_slow(slow), .o_ready(i_ready_pin));

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask

  function [7:0] mux(input [7:0] s, input [7:0] a, input [7:0] b);
    mux = (s & a) | (~s & b);
  endfunction

  // four edges are just enough for the strap to pass the pin filter
  task do_reset(input strap);
    begin
      @(negedge i_ref_clk);
      i_reset = 1'b1;
      i_emul_isolate_pin = strap;
      repeat (4) @(negedge i_ref_clk);
      i_reset = 1'b0;
      repeat (3) @(negedge i_ref_clk);
    end
  endtask

  task bus(input e, input rd, input [1:0] w, input [3:0] s);
    integer n, exp;
    begin
      slow = s;
      repeat (6) @(negedge i_ref_clk);
      {i_bus_req, i_bus_ext, i_bus_read, i_bus_wait} = {1'b1, e, rd, w};
      @(negedge i_ref_clk);
      n = 1;
      chk("rd_n start", o_rd_n, !(e && rd));
      // on external cycles a second request lands while busy and must be dropped
      i_bus_req = e;
      while (o_bus_done !== 1'b1 && n < 40) begin
        @(negedge i_ref_clk);
        i_bus_req = 1'b0;
        n = n + 1;
      end
      // ready reaches the state machine five edges after the pin moves
      if (!e) exp = 2;
      else if (s == 0 || w + 3 > s + 6) exp = w + 3;
      else exp = s + 6;
      chk("cycle length", n, exp);
      chk("rd_n end", o_rd_n, 1);
      repeat (2) @(negedge i_ref_clk);
      chk("busy after", o_bus_busy, 0);
    end
  endtask

  initial begin
    {i_reset, i_emul_isolate_pin, i_bus_req, i_bus_ext, i_bus_read} = 5'h10;
    {i_p1_pin, i_p1_gp_out, i_p1_gp_oe, i_p1_sel, i_p1_sf_out} = 40'h0;
    {i_p1_sf_oe, i_p2_pin, i_p2_gp_out, i_p2_gp_oe, i_p2_sel} = 40'h0;
    {i_p2_sf_out, i_p2_sf_oe, i_p3_pin, i_p3_gp_out, i_p3_sel} = 40'h0;
    {i_p3_gp_oe, i_chip_select_outputs, i_p4_pin, i_p4_gp_out} = 22'h0;
    {i_p4_gp_oe, i_p4_sel, slow, i_pwm_enable, i_bus_wait} = 17'h0;
    {i_pwm_period, i_pwm_duty, i_bus_hold_ack_n} = 49'h1;
    do_reset(1'b0);
    chk("isolated", o_isolated, 0);
    chk("rd_n_oe", o_rd_n_oe, 1);
    {i_p1_gp_oe, i_p2_gp_oe, i_p3_gp_oe, i_p4_gp_oe} = 28'hFFFFFFF;
    do_reset(1'b1);
    chk("isolated", o_isolated, 1);
    chk("oe iso", {o_p1_oe, o_p2_oe, o_p3_oe, o_p4_oe, o_rd_n_oe}, 0);
    i_emul_isolate_pin = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    chk("isolated held", o_isolated, 1);
    chk("oe held", {o_p1_oe, o_p2_oe, o_p3_oe, o_p4_oe}, 0);
    do_reset(1'b0);
    chk("isolated left", o_isolated, 0);
    for (i = 0; i < 8; i = i + 1) begin
      r = $random(seed);
      {i_p1_sel, i_p1_gp_out, i_p1_gp_oe, i_p1_sf_out} = r;
      r = $random(seed);
      {i_p1_sf_oe, i_p2_sel, i_p2_gp_out, i_p2_gp_oe} = r;
      r = $random(seed);
      {i_p2_sf_out, i_p2_sf_oe, i_p3_sel, i_p3_gp_out} = r;
      r = $random(seed);
      {i_p3_gp_oe, i_p4_sel, i_p4_gp_out, i_p4_gp_oe} = r[19:0];
      {i_chip_select_outputs, i_bus_hold_ack_n} = r[26:20];
      @(negedge i_ref_clk);
      chk("p1 out", o_p1_out,
        mux(i_p1_sel, i_p1_sf_out, i_p1_gp_out));
      chk("p1 oe", o_p1_oe, mux(i_p1_sel, i_p1_sf_oe, i_p1_gp_oe));
      chk("p2 out", o_p2_out, mux(i_p2_sel, {i_p2_sf_out[7],
        i_bus_hold_ack_n, i_p2_sf_out[5:0]}, i_p2_gp_out));
      chk("p2 oe", o_p2_oe,
        mux(i_p2_sel, i_p2_sf_oe | 8'h40, i_p2_gp_oe));
      chk("p3 out", o_p3_out & ~(i_p3_sel & 8'hC0), mux(i_p3_sel,
        {2'h0, i_chip_select_outputs}, i_p3_gp_out) & ~(i_p3_sel & 8'hC0));
      chk("p3 oe", o_p3_oe, mux(i_p3_sel, 8'h3F, i_p3_gp_oe));
      chk("p4 oe", o_p4_oe, mux(i_p4_sel, 8'h07, i_p4_gp_oe));
      chk("p4 out", o_p4_out & ~(i_p4_sel & 4'h8),
        mux(i_p4_sel, 8'h00, i_p4_gp_out) & ~(i_p4_sel & 8'h08));
    end
    r = $random(seed);
    {i_p1_pin, i_p2_pin, i_p3_pin, i_p4_pin} = r[27:0];
    repeat (5) @(negedge i_ref_clk);
    chk("p1 in", o_p1_in, i_p1_pin);
    chk("p1 special", {o_timer_one_dir_in, o_timer_one_clock_in,
      o_capture_channel_pins}, i_p1_pin[5:0]);
    chk("p2 in", o_p2_in, i_p2_pin);
    chk("p3 in", o_p3_in, i_p3_pin);
    chk("irq in", {o_ext_irq_three, o_ext_irq_two}, i_p3_pin[7:6]);
    chk("p4 in", o_p4_in, i_p4_pin);
    i_pwm_period = 24'h050403;
    i_pwm_duty = 24'h030201;
    i_pwm_enable = 3'h7;
    i_p4_sel = 4'h7;
    repeat (12) @(negedge i_ref_clk);
    for (k = 0; k < 20; k = k + 1) begin
      @(negedge i_ref_clk);
      for (g = 0; g < 3; g = g + 1) smp[g * 20 + k] = o_p4_out[g];
    end
    // a channel repeats every period plus one cycles, high for duty
    for (g = 0; g < 3; g = g + 1) begin
      ones = 0;
      bad = 0;
      for (k = 0; k < g + 4; k = k + 1) ones = ones + smp[g * 20 + k];
      for (k = 0; k < 16 - g; k = k + 1)
        if (smp[g * 20 + k] !== smp[g * 20 + k + g + 4]) bad = bad + 1;
      chk("wave duty", ones, g + 1);
      chk("wave period", bad, 0);
    end
    bus(1'b0, 1'b1, 2'h3, 4'h0);
    bus(1'b0, 1'b1, 2'h0, 4'h3);
    bus(1'b0, 1'b0, 2'h1, 4'h0);
    bus(1'b1, 1'b1, 2'h0, 4'h0);
    bus(1'b1, 1'b1, 2'h3, 4'h0);
    bus(1'b1, 1'b0, 2'h2, 4'h0);
    bus(1'b1, 1'b1, 2'h0, 4'h2);
    bus(1'b1, 1'b1, 2'h2, 4'h1);
    bus(1'b1, 1'b1, 2'h1, 4'h6);
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares = miscompares + 1;
    end_of_test;
  end
endmodule // tb
